/* design/hfs_fan_ctrl.sv */
// Purpose: two-channel heatsink fan controller, temperature loop, speed loop, pwm, tach
// Assumes: pin inputs synchronous to clk; settings held steady by software
// Notes: loops run every LOOP_PERIOD_CYCLES; speed measured once per tach window
// Contract
// - pwm at 25 kHz or 1 kHz, 0-100 %
// - pwm only on the two pulse pins
// - tach input selectable from any general pin
// - two independent fan channels
// - temperature loop yields required cooling power
// - recommended temperature gain 30 %/degC, P only
// - power maps linearly between min and max speed
// - speed loop trims duty to nominal speed
// - bypass sends cooling power straight to duty
// - external stop pin halts the fan
// - start/stop hysteresis, zero threshold ignored
// - per-channel enable, disabled means no control
// - actual temperature from sink, object or device
// - separate set point and gains per loop
// - limit and stalled errors, masked without surveillance
// - negative level inverts pin outputs and inputs
`timescale 1ns/1ps
module hfs_fan_ctrl
  import hfs_pkg::*;
#(
  parameter int unsigned PWM_SLOW_CYCLES = PWM_SLOW_CYC,
  parameter int unsigned TACH_WINDOW_CYCLES = TACH_WINDOW_CYC,
  parameter int unsigned LOOP_PERIOD_CYCLES = LOOP_PERIOD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // channel settings and status
  input wire hfs_chan_cfg_t [NUM_CH-1:0] chan_cfg,
  output hfs_chan_stat_t [NUM_CH-1:0] chan_status,
  // temperatures
  input wire hfs_temp_t [NUM_CH-1:0] sink_temp,
  input wire hfs_temp_t [NUM_CH-1:0] object_temp,
  input wire hfs_temp_t device_temp,
  // general-purpose pins, input side
  input wire logic [NUM_PINS-1:0] gpio_in,
  input wire logic [NUM_PINS-1:0] gpio_neg_level,
  // pulse-capable pins: index 0 is pin a, 1 is pin b
  input wire logic [1:0] pwm_pin_en,
  input wire logic [1:0] pwm_pin_chan,
  input wire logic [1:0] pwm_pin_neg_level,
  input wire logic [1:0] push_pull_output_config,
  output logic pulse_capable_pin_a,
  output logic pulse_capable_pin_a_oe,
  output logic pulse_capable_pin_b,
  output logic pulse_capable_pin_b_oe
);

  function automatic logic [9:0] sat_duty(input logic signed [39:0] v);
    logic [9:0] r;
    if (v < 40'sh0) begin
      r = DUTY_RESET;
    end else if (v > DUTY_FULL_WIDE) begin
      r = DUTY_FULL;
    end else begin
      r = 10'(v);
    end
    return r;
  endfunction

  // one discrete pid step; itime is a shift (0 = no integral), dtime a factor
  function automatic hfs_pid_t pid_step(input hfs_pid_t st, input logic signed [19:0] err,
      input logic [15:0] gain, input logic [4:0] itime, input logic [7:0] dtime);
    logic signed [39:0] g;
    logic signed [39:0] p;
    logic signed [39:0] d;
    logic signed [39:0] acc;
    hfs_pid_t nx;
    g = 40'(signed'({1'b0, gain}));
    p = (g * 40'(err)) >>> GAIN_FRAC_BITS;
    d = ((g * (40'(err) - 40'(st.prev_err))) >>> GAIN_FRAC_BITS)
        * 40'(signed'({1'b0, dtime}));
    acc = 40'(st.acc);
    if (itime != 5'h0) begin
      acc = acc + (p >>> itime);
    end
    // clamp the integrator to the output span so it cannot wind up
    nx.acc = 16'(sat_duty(acc));
    nx.prev_err = err;
    nx.out = sat_duty(p + 40'(nx.acc) + d);
    return nx;
  endfunction

  localparam hfs_pid_t PID_RESET = '{acc: 16'sh0, prev_err: 20'sh0, out: DUTY_RESET};

  logic [NUM_PINS-1:0] gpio_lvl;
  logic [31:0] loop_cnt_r;
  logic [31:0] tach_cnt_r;
  logic loop_tick;
  logic tach_tick;
  logic [NUM_CH-1:0] pwm_of;
  logic [1:0] pin_out_r;

  assign gpio_lvl = gpio_in ^ gpio_neg_level;
  assign loop_tick = (loop_cnt_r == 32'(LOOP_PERIOD_CYCLES - 1));
  assign tach_tick = (tach_cnt_r == 32'(TACH_WINDOW_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!reset_n || loop_tick) begin
      loop_cnt_r <= 32'h0;
    end else begin
      loop_cnt_r <= loop_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || tach_tick) begin
      tach_cnt_r <= 32'h0;
    end else begin
      tach_cnt_r <= tach_cnt_r + 32'h1;
    end
  end

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    hfs_chan_cfg_t cfg;
    hfs_temp_t t_act;
    logic signed [19:0] t_err;
    logic signed [19:0] s_err;
    logic [15:0] t_gain;
    logic [15:0] span;
    logic [9:0] power;
    logic stop_req;
    logic start_ok;
    logic stop_now;
    logic [16:0] period;
    logic [26:0] thr_prod;
    logic [16:0] thr;
    logic tach_lvl;
    logic [31:0] rpm_full;
    hfs_pid_t tpid_r;
    hfs_pid_t spid_r;
    hfs_fan_state_t state_r;
    logic [15:0] nominal_r;
    logic [15:0] rpm_r;
    logic [15:0] edges_r;
    logic tach_prev_r;
    logic [9:0] duty_r;
    logic [16:0] pwm_cnt_r;
    logic pwm_r;
    logic limit_r;
    logic stalled_r;
    logic [7:0] err_code_r;

    assign cfg = chan_cfg[ch];

    always_comb begin
      unique case (cfg.temp_src)
        HFS_SRC_SINK: t_act = sink_temp[ch];
        HFS_SRC_OBJECT: t_act = object_temp[ch];
        HFS_SRC_DEVICE: t_act = device_temp;
        default: t_act = device_temp;
      endcase
    end

    // hotter than target gives positive error and more cooling
    assign t_err = 20'(t_act) - 20'(cfg.target_temp);
    assign t_gain = (cfg.temp_proportional_gain == 16'h0) ? TEMP_GAIN_RECOMMENDED
                    : cfg.temp_proportional_gain;
    assign power = tpid_r.out;
    assign s_err = 20'(signed'({1'b0, nominal_r})) - 20'(signed'({1'b0, rpm_r}));
    assign stop_req = cfg.stop_pin_en && gpio_lvl[cfg.stop_pin];
    assign start_ok = (cfg.start_speed_rpm == 16'h0) || (nominal_r > cfg.start_speed_rpm);
    assign stop_now = (cfg.stop_speed_rpm != 16'h0) && (nominal_r < cfg.stop_speed_rpm);

    // temperature loop, own set point and gains
    always_ff @(posedge clk) begin
      if (!reset_n || !cfg.enable) begin
        tpid_r <= PID_RESET;
      end else if (loop_tick) begin
        tpid_r <= pid_step(tpid_r, t_err, t_gain, cfg.temp_integral_time,
                           cfg.temp_derivative_time);
      end
    end

    // nominal speed by linear interpolation of cooling power
    assign span = (cfg.speed_max_rpm > cfg.speed_min_rpm)
                  ? (cfg.speed_max_rpm - cfg.speed_min_rpm) : 16'h0;
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        nominal_r <= RPM_RESET;
      end else begin
        nominal_r <= cfg.speed_min_rpm
                     + 16'((32'(span) * 32'(power)) / 32'(DUTY_FULL));
      end
    end

    // start/stop hysteresis
    always_ff @(posedge clk) begin
      if (!reset_n || !cfg.enable || stop_req) begin
        state_r <= HFS_FAN_OFF;
      end else begin
        unique case (state_r)
          HFS_FAN_OFF: begin
            if (start_ok) begin
              state_r <= HFS_FAN_RUN;
            end
          end
          HFS_FAN_RUN: begin
            if (stop_now) begin
              state_r <= HFS_FAN_OFF;
            end
          end
          default: state_r <= HFS_FAN_OFF;
        endcase
      end
    end

    // speed loop, idle and cleared while bypassed or stopped
    always_ff @(posedge clk) begin
      if (!reset_n || state_r != HFS_FAN_RUN || cfg.bypass_speed_loop) begin
        spid_r <= PID_RESET;
      end else if (loop_tick) begin
        spid_r <= pid_step(spid_r, s_err, cfg.speed_proportional_gain,
                           cfg.speed_integral_time, cfg.speed_derivative_time);
      end
    end

    always_ff @(posedge clk) begin
      if (!reset_n || !cfg.enable || state_r != HFS_FAN_RUN || stop_req) begin
        duty_r <= DUTY_RESET;
      end else if (cfg.bypass_speed_loop) begin
        duty_r <= power;
      end else begin
        duty_r <= spid_r.out;
      end
    end

    // pwm carrier; full duty never drops, zero duty never rises
    assign period = cfg.pwm_slow ? 17'(PWM_SLOW_CYCLES) : 17'(PWM_FAST_CYC);
    assign thr_prod = 27'(period) * 27'(duty_r);
    assign thr = 17'(thr_prod / 27'(DUTY_FULL));

    always_ff @(posedge clk) begin
      if (!reset_n || pwm_cnt_r >= period - 17'h1) begin
        pwm_cnt_r <= 17'h0;
      end else begin
        pwm_cnt_r <= pwm_cnt_r + 17'h1;
      end
    end

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        pwm_r <= 1'b0;
      end else begin
        pwm_r <= (pwm_cnt_r < thr);
      end
    end
    assign pwm_of[ch] = pwm_r;

    // tachometer: rising edges counted over one gate window
    assign tach_lvl = gpio_lvl[cfg.tach_pin];
    assign rpm_full = (32'(edges_r) * 32'(RPM_PER_EDGE)) >> cfg.pulses_per_rev_log2;

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        // track the idle line level so release of reset is not counted as a rise
        tach_prev_r <= tach_lvl;
        edges_r <= 16'h0;
        rpm_r <= RPM_RESET;
      end else begin
        tach_prev_r <= tach_lvl;
        if (tach_tick) begin
          edges_r <= 16'h0;
          // saturate rather than wrap on an absurd edge count
          rpm_r <= (rpm_full > 32'h0000_FFFF) ? 16'hFFFF : rpm_full[15:0];
        end else if (tach_lvl && !tach_prev_r && edges_r != 16'hFFFF) begin
          edges_r <= edges_r + 16'h1;
        end
      end
    end

    // fault detection, held clear while surveillance is off
    always_ff @(posedge clk) begin
      if (!reset_n || !cfg.surveillance || !cfg.enable) begin
        limit_r <= 1'b0;
        stalled_r <= 1'b0;
      end else begin
        if (loop_tick) begin
          limit_r <= (state_r == HFS_FAN_RUN) && !cfg.bypass_speed_loop
                     && (spid_r.out == DUTY_FULL) && (rpm_r < nominal_r);
        end
        if (tach_tick) begin
          stalled_r <= (state_r == HFS_FAN_RUN) && (duty_r != DUTY_RESET)
                       && (edges_r == 16'h0);
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        err_code_r <= ERR_NONE;
      end else if (stalled_r) begin
        err_code_r <= ERR_FAN_STALLED;
      end else if (limit_r) begin
        err_code_r <= ERR_FAN_LIMIT;
      end else begin
        err_code_r <= ERR_NONE;
      end
    end

    assign chan_status[ch] = '{speed_rpm: rpm_r, nominal_rpm: nominal_r, duty: duty_r,
                               running: (state_r == HFS_FAN_RUN), limit_error: limit_r,
                               fan_stalled_error: stalled_r, err_code: err_code_r};
  end

  // only these two pins can carry a fan pwm waveform
  for (genvar pn = 0; pn < 2; pn++) begin : g_pin
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        pin_out_r[pn] <= 1'b0;
      end else begin
        pin_out_r[pn] <= (pwm_pin_en[pn] && pwm_of[pwm_pin_chan[pn]])
                         ^ pwm_pin_neg_level[pn];
      end
    end
  end

  assign pulse_capable_pin_a = pin_out_r[0];
  assign pulse_capable_pin_b = pin_out_r[1];
  assign pulse_capable_pin_a_oe = push_pull_output_config[0];
  assign pulse_capable_pin_b_oe = push_pull_output_config[1];

endmodule

/* design/hfs_pkg.sv */
// Purpose: shared constants and types for the heatsink fan speed controller
// Assumes: 100 MHz clock; temperatures in signed 0.01 degC steps; duty in 0.1 % steps
// Notes: gains are unsigned Q8.8 factors of duty steps per unit of error
package hfs_pkg;

  localparam int unsigned NUM_CH = 2;
  localparam int unsigned NUM_PINS = 8;
  localparam int unsigned CLK_HZ = 100_000_000;

  // pwm carrier frequencies
  localparam int unsigned PWM_FAST_HZ = 25_000;
  localparam int unsigned PWM_SLOW_HZ = 1_000;
  localparam int unsigned PWM_FAST_CYC = CLK_HZ / PWM_FAST_HZ;
  localparam int unsigned PWM_SLOW_CYC = CLK_HZ / PWM_SLOW_HZ;

  // tachometer gate time and the rpm factor that goes with it
  localparam int unsigned TACH_WINDOW_MS = 1000;
  localparam int unsigned TACH_WINDOW_CYC = TACH_WINDOW_MS * (CLK_HZ / 1000);
  localparam int unsigned RPM_PER_EDGE = 60_000 / TACH_WINDOW_MS;

  // update period of both control loops
  localparam int unsigned LOOP_PERIOD_MS = 10;
  localparam int unsigned LOOP_PERIOD_CYC = LOOP_PERIOD_MS * (CLK_HZ / 1000);

  localparam logic [9:0] DUTY_FULL = 10'h3E8;
  localparam logic signed [39:0] DUTY_FULL_WIDE = 40'sh00_0000_03E8;
  localparam int unsigned GAIN_FRAC_BITS = 8;
  // 30 %/degC = 3 duty steps per 0.01 degC, in Q8.8
  localparam logic [15:0] TEMP_GAIN_RECOMMENDED = 16'h0300;

  // error numbers reported per channel
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_FAN_LIMIT = 8'hAF;
  localparam logic [7:0] ERR_FAN_STALLED = 8'hB0;

  // reset values
  localparam logic [15:0] RPM_RESET = 16'h0000;
  localparam logic [9:0] DUTY_RESET = 10'h000;

  typedef logic signed [15:0] hfs_temp_t;

  typedef enum logic [1:0] {
    HFS_SRC_SINK = 2'h0,
    HFS_SRC_OBJECT = 2'h1,
    HFS_SRC_DEVICE = 2'h2
  } hfs_temp_src_t;

  typedef enum logic [1:0] {
    HFS_FAN_OFF = 2'h1,
    HFS_FAN_RUN = 2'h2
  } hfs_fan_state_t;

  typedef struct packed {
    logic enable;
    hfs_temp_src_t temp_src;
    hfs_temp_t target_temp;
    logic [15:0] temp_proportional_gain;
    logic [4:0] temp_integral_time;
    logic [7:0] temp_derivative_time;
    logic [15:0] speed_min_rpm;
    logic [15:0] speed_max_rpm;
    logic [15:0] start_speed_rpm;
    logic [15:0] stop_speed_rpm;
    logic [15:0] speed_proportional_gain;
    logic [4:0] speed_integral_time;
    logic [7:0] speed_derivative_time;
    logic bypass_speed_loop;
    logic surveillance;
    logic pwm_slow;
    logic [2:0] tach_pin;
    logic stop_pin_en;
    logic [2:0] stop_pin;
    logic [1:0] pulses_per_rev_log2;
  } hfs_chan_cfg_t;

  typedef struct packed {
    logic signed [15:0] acc;
    logic signed [19:0] prev_err;
    logic [9:0] out;
  } hfs_pid_t;

  typedef struct packed {
    logic [15:0] speed_rpm;
    logic [15:0] nominal_rpm;
    logic [9:0] duty;
    logic running;
    logic limit_error;
    logic fan_stalled_error;
    logic [7:0] err_code;
  } hfs_chan_stat_t;

endpackage

/* test/hfs_fan_ctrl_chk.sv */
// Purpose: port-level assertions for the fan controller
// Assumes: channel 0 carries the stop and error checks
// Notes: pin level checks look at pin a only
`timescale 1ns/1ps
module hfs_fan_ctrl_chk
  import hfs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // channels
  input wire hfs_chan_cfg_t [NUM_CH-1:0] chan_cfg,
  input wire hfs_chan_stat_t [NUM_CH-1:0] chan_status,
  // pins
  input wire logic [NUM_PINS-1:0] gpio_in,
  input wire logic [NUM_PINS-1:0] gpio_neg_level,
  input wire logic [1:0] pwm_pin_en,
  input wire logic [1:0] pwm_pin_chan,
  input wire logic [1:0] pwm_pin_neg_level,
  input wire logic [1:0] push_pull_output_config,
  input wire logic pulse_capable_pin_a,
  input wire logic pulse_capable_pin_a_oe,
  input wire logic pulse_capable_pin_b_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic stop0;
  logic [9:0] duty_a;
  assign stop0 = chan_cfg[0].stop_pin_en
    && (gpio_in[chan_cfg[0].stop_pin] ^ gpio_neg_level[chan_cfg[0].stop_pin]);
  assign duty_a = chan_status[pwm_pin_chan[0]].duty;

  chk_oe_direct: assert property ({pulse_capable_pin_b_oe, pulse_capable_pin_a_oe} == push_pull_output_config)
    else $error("pin drive enable differs from config");
  chk_duty_range: assert property (chan_status[0].duty <= DUTY_FULL && chan_status[1].duty <= DUTY_FULL)
    else $error("duty above full scale");
  chk_off_idle_a: assert property (!chan_cfg[0].enable |=> chan_status[0].duty == 0 && !chan_status[0].running)
    else $error("disabled channel 0 still drives");
  chk_off_idle_b: assert property (!chan_cfg[1].enable |=> chan_status[1].duty == 0 && !chan_status[1].running)
    else $error("disabled channel 1 still drives");
  chk_stop_halts: assert property (stop0 |=> chan_status[0].duty == 0 && !chan_status[0].running)
    else $error("stop pin did not halt fan");
  chk_surv_masks: assert property (!chan_cfg[0].surveillance |=> !chan_status[0].limit_error && !chan_status[0].fan_stalled_error)
    else $error("errors not masked");
  chk_stall_code: assert property (chan_status[0].fan_stalled_error && chan_cfg[0].surveillance && chan_cfg[0].enable |=> chan_status[0].err_code == ERR_FAN_STALLED)
    else $error("stalled code missing");
  chk_pin_idle: assert property (!pwm_pin_en[0] |=> pulse_capable_pin_a == $past(pwm_pin_neg_level[0]))
    else $error("idle pin not at level");
  chk_pin_zero: assert property ((pwm_pin_en[0] && duty_a == 0) [*3] |=> pulse_capable_pin_a == $past(pwm_pin_neg_level[0]))
    else $error("zero duty pin active");
  chk_pin_full: assert property ((pwm_pin_en[0] && duty_a == DUTY_FULL) [*3] |=> pulse_capable_pin_a != $past(pwm_pin_neg_level[0]))
    else $error("full duty pin inactive");
  cover property ($rose(chan_status[0].running));
  cover property (chan_status[0].fan_stalled_error);
  cover property (chan_status[0].limit_error);
endmodule
bind hfs_fan_ctrl hfs_fan_ctrl_chk i_chk (
  .clk(clk), .reset_n(reset_n), .chan_cfg(chan_cfg), .chan_status(chan_status),
  .gpio_in(gpio_in), .gpio_neg_level(gpio_neg_level), .pwm_pin_en(pwm_pin_en),
  .pwm_pin_chan(pwm_pin_chan), .pwm_pin_neg_level(pwm_pin_neg_level),
  .push_pull_output_config(push_pull_output_config), .pulse_capable_pin_a(pulse_capable_pin_a),
  .pulse_capable_pin_a_oe(pulse_capable_pin_a_oe), .pulse_capable_pin_b_oe(pulse_capable_pin_b_oe)
);

/* test/hfs_fan_ctrl_test.sv */
// Purpose: self-checking bench for the fan controller
// Assumes: shortened loop, tach window and slow pwm periods
// Notes: tach checks allow one edge of window phase slack
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin failures++; \
  $display("unexpected %s expected %0d seen %0d", n, e, s); end end
module hfs_fan_ctrl_test;
  import hfs_pkg::*;
  localparam int LP = 50;
  localparam int TW = 2000;
  localparam int PS = 400;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  hfs_chan_cfg_t [NUM_CH-1:0] cfg;
  hfs_chan_stat_t [NUM_CH-1:0] st;
  hfs_temp_t [NUM_CH-1:0] sink_t;
  hfs_temp_t [NUM_CH-1:0] obj_t;
  hfs_temp_t dev_t;
  logic [NUM_PINS-1:0] gin, gneg, gpio_w;
  logic [1:0] pen, pchan, pneg, ppc;
  logic pa, pb, tach, blocked;
  int failures = 0;
  int samples_checked = 0;
  int run_st[2];
  int exp_duty[2];
  int tpin, ppr, d;
  hfs_temp_t hyst[5] = '{16'sh1004, 16'sh1068, 16'sh1004, 16'sh0FC1, 16'sh1004};
  always #5 clk = ~clk;
  assign gpio_w = gin | ({7'h00, tach} << cfg[0].tach_pin);
  hfs_fan_ctrl #(.PWM_SLOW_CYCLES(PS), .TACH_WINDOW_CYCLES(TW), .LOOP_PERIOD_CYCLES(LP)) i_dut (
    .clk(clk), .reset_n(reset_n), .chan_cfg(cfg), .chan_status(st), .sink_temp(sink_t),
    .object_temp(obj_t), .device_temp(dev_t), .gpio_in(gpio_w), .gpio_neg_level(gneg),
    .pwm_pin_en(pen), .pwm_pin_chan(pchan), .pwm_pin_neg_level(pneg),
    .push_pull_output_config(ppc), .pulse_capable_pin_a(pa), .pulse_capable_pin_a_oe(),
    .pulse_capable_pin_b(pb), .pulse_capable_pin_b_oe());
  hfs_fan_model i_fan (.clk(clk), .pwm(pa ^ pneg[0]), .blocked(blocked), .tach(tach));

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  function automatic int power(int ch);
    int a;
    int g;
    int p;
    a = cfg[ch].temp_src == HFS_SRC_SINK ? sink_t[ch]
      : cfg[ch].temp_src == HFS_SRC_OBJECT ? obj_t[ch] : dev_t;
    g = cfg[ch].temp_proportional_gain == 0 ? 768 : cfg[ch].temp_proportional_gain;
    p = (g * (a - cfg[ch].target_temp)) >>> 8;
    return p < 0 ? 0 : (p > 1000 ? 1000 : p);
  endfunction
  task automatic expect_chan(input int ch);
    int p;
    int n;
    int stp;
    p = power(ch);
    n = cfg[ch].speed_min_rpm + (cfg[ch].speed_max_rpm - cfg[ch].speed_min_rpm) * p / 1000;
    stp = cfg[ch].stop_pin_en && (gin[cfg[ch].stop_pin] ^ gneg[cfg[ch].stop_pin]);
    if (!cfg[ch].enable || stp)
      run_st[ch] = 0;
    else if (run_st[ch] == 0)
      run_st[ch] = cfg[ch].start_speed_rpm == 0 || n > cfg[ch].start_speed_rpm;
    else
      run_st[ch] = cfg[ch].stop_speed_rpm == 0 || n >= cfg[ch].stop_speed_rpm;
    exp_duty[ch] = run_st[ch] ? p : 0;
    `CHK("running", run_st[ch], st[ch].running)
    `CHK("duty", exp_duty[ch], st[ch].duty)
    if (cfg[ch].enable && stp == 0)
      `CHK("nominal", n, st[ch].nominal_rpm)
  endtask
  task automatic pwm_check(input int ch, input int e, input int per);
    int h;
    h = 0;
    repeat (per) begin
      @(negedge clk);
      h += int'(ch ? pb ^ pneg[1] : pa ^ pneg[0]);
    end
    `CHK("pwm high", 1, int'(h * 1000 - e * per <= 1000 && e * per - h * 1000 <= 1000))
  endtask
  task automatic give_verdict;
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h694D8CB4));
    cfg = '0;
    sink_t = {16'sh0FD2, 16'sh1004};
    obj_t = {16'sh1068, 16'sh1068};
    dev_t = 16'sh10FE;
    gin = '0;
    gneg = '0;
    pen = 2'h3;
    pchan = 2'h2;
    pneg = 2'h0;
    ppc = 2'($urandom);
    blocked = 1'b0;
    tpin = $urandom % 7;
    // pin 5 is kept for the stop function
    if (tpin >= 5)
      tpin++;
    ppr = $urandom % 4;
    for (int c = 0; c < 2; c++) begin
      cfg[c].target_temp = 16'sh0FA0;
      cfg[c].speed_min_rpm = 16'h03E8;
      cfg[c].speed_max_rpm = 16'h2AF8;
      cfg[c].bypass_speed_loop = 1'b1;
      cfg[c].surveillance = 1'b1;
      cfg[c].tach_pin = 3'(tpin);
      cfg[c].stop_pin = 3'h5;
      cfg[c].pulses_per_rev_log2 = 2'(ppr);
    end
    tick(3);
    `CHK("reset duty", 0, st[0].duty)
    reset_n = 1'b1;
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 3; s++) begin
        cfg[0].enable = c == 0;
        cfg[1].enable = c == 1;
        cfg[c].temp_src = hfs_temp_src_t'(s);
        tick(4 * LP);
        expect_chan(0);
        expect_chan(1);
        if (s == 0)
          pwm_check(c, exp_duty[c], int'(PWM_FAST_CYC));
      end
    end
    pen = 2'h2;
    tick(3);
    `CHK("idle pin", pneg[0], pa)
    pen = 2'h3;
    cfg[1].enable = 1'b0;
    cfg[0].enable = 1'b1;
    cfg[0].temp_src = HFS_SRC_SINK;
    cfg[0].pwm_slow = 1'b1;
    pneg = 2'h1;
    tick(4 * LP);
    expect_chan(0);
    pwm_check(0, exp_duty[0], PS);
    cfg[0].pwm_slow = 1'b0;
    pneg = 2'h0;
    cfg[0].enable = 1'b0;
    tick(LP);
    expect_chan(0);
    cfg[0].enable = 1'b1;
    cfg[0].start_speed_rpm = 16'h1388;
    cfg[0].stop_speed_rpm = 16'h0BB8;
    foreach (hyst[i]) begin
      sink_t[0] = hyst[i];
      tick(4 * LP);
      expect_chan(0);
    end
    cfg[0].start_speed_rpm = 16'h0000;
    cfg[0].stop_speed_rpm = 16'h0000;
    sink_t[0] = 16'sh1068;
    cfg[0].stop_pin_en = 1'b1;
    gneg[5] = 1'b1;
    for (int v = 1; v >= 0; v--) begin
      gin[5] = 1'(v);
      tick(4 * LP);
      expect_chan(0);
    end
    gin[5] = 1'b1;
    tick(3 * TW);
    expect_chan(0);
    // a gate window holds 39 or 40 rises, depending on tach phase
    d = int'(st[0].speed_rpm);
    `CHK("speed", 1, int'(d >= (2340 >> ppr) && d <= (2400 >> ppr)))
    blocked = 1'b1;
    for (int i = 0; i < 3 * TW && st[0].fan_stalled_error !== 1'b1; i++)
      @(negedge clk);
    `CHK("stall seen", 1, st[0].fan_stalled_error)
    tick(2);
    `CHK("stalled code", ERR_FAN_STALLED, st[0].err_code)
    cfg[0].bypass_speed_loop = 1'b0;
    cfg[0].speed_proportional_gain = 16'h0100;
    tick(4 * LP);
    `CHK("loop duty", DUTY_FULL, st[0].duty)
    `CHK("limit", 1, st[0].limit_error)
    cfg[0].surveillance = 1'b0;
    tick(3);
    `CHK("masked", 0, {st[0].limit_error, st[0].fan_stalled_error, st[0].err_code})
    give_verdict();
  end
endmodule

/* test/hfs_fan_model.sv */
// Purpose: behavioural cooling fan with pwm input and tachometer output
// Assumes: tach line is open collector with a pull-up
// Notes: spins while pwm went high within HOLD cycles
`timescale 1ns/1ps
module hfs_fan_model #(
  parameter int HALF = 25,
  parameter int HOLD = 4100
) (
  // clock
  input wire logic clk,
  // fan side
  input wire logic pwm,
  input wire logic blocked,
  output logic tach
);
  int idle = HOLD;
  int ph = 0;
  initial tach = 1'b1;
  always @(posedge clk) begin
    if (pwm)
      idle <= 0;
    else if (idle < HOLD)
      idle <= idle + 1;
    // a stalled or idle fan releases the line, so the pull-up reads high
    if (blocked || idle >= HOLD)
      tach <= 1'b1;
    else begin
      ph <= (ph + 1) % (2 * HALF);
      tach <= ph < HALF;
    end
  end
endmodule
